// ### verilog/phase_rms_and_active_power.sv
// Purpose: Per-phase current mean-abs, voltage rms and total active power
// Assumes: Samples on phaseSamples are synchronous and valid at all times
// Notes:   One shared square-root engine walks the phases after each tick
`timescale 1ns/1ns

// How it works
// - Current high-passed, rectified, averaged; mean-abs updated at 8 kHz.
// - Mean-abs word is 20 bits unsigned, top 12 bits read zero.
// - Full-scale sine mean-abs about 209,686 (50 Hz), 210,921 (60 Hz).
// - Mean-abs settles within 0.5% in 500 ms; first result may be slower.
// - Voltage rms is low-passed square then root, refreshed at 8 kHz.
// - Full-scale sine voltage rms reads 4,191,910 at any line frequency.
// - Voltage rms reaches applied value from zero within 440 ms.
// - Voltage rms read as 32 bits, top eight bits zero.
// - Offset coefficient times 128 added to mean square before root.
// - Offset coefficient reads with four zero bits, sign-extended to 28.
// - Total active power includes fundamental and every harmonic.
// - Each phase multiplies current by voltage, second low-pass extracts dc.
// - Stored power is fraction of 33,516,139 full-scale power over 16.
// - Each 24-bit power word is readable on the serial port.
// - Power may carry double-line-frequency ripple; integration removes it.
// - Fundamental-only power exists only on the variant that supports it.
module phase_rms_and_active_power
  import phase_meter_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV      = SAMPLE_DIV_CYC,
  parameter bit          FUNDAMENTAL_EN  = 1'b0
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire phase_sample_t [PHASES-1:0] phaseSamples,
  input  wire reg_req_t                 regReq,
  output logic [31:0]                   regRdata,
  output logic                          regRvalid,
  output logic                          resultUpdate
);

  localparam int FRAME_CYC = PHASES * (ROOT_W + 2);

  // Parameter checks
  initial begin
    if (SAMPLE_DIV <= FRAME_CYC + 1)
      $error("SAMPLE_DIV too small for one phase sweep");
    // Fundamental-only power is not part of this variant
    if (FUNDAMENTAL_EN)
      $error("fundamental-only power not available on this variant");
    if (VRMS_SHIFT > 14 || PWR_SHIFT > 14 || MAV_SHIFT > 14)
      $error("filter shift would overflow 64-bit accumulators");
  end

  typedef enum logic [1:0] {IDLE, FILTER, ROOT, STORE} step_t;

  localparam logic [31:0] DIV_LAST = 32'(SAMPLE_DIV - 1);

  // Frame state
  step_t                       step,    next_step;
  logic [31:0]                 tickCnt, next_tickCnt;
  logic [1:0]                  phase,   next_phase;
  logic [4:0]                  bitIdx,  next_bitIdx;
  logic [ROOT_W-1:0]           root,    next_root;
  logic                        next_resultUpdate;
  phase_sample_t [PHASES-1:0]  held,    next_held;
  logic signed [63:0]          hpAcc    [PHASES];
  logic signed [63:0]          mavAcc   [PHASES];
  logic signed [63:0]          msqAcc   [PHASES];
  logic signed [63:0]          pwrAcc   [PHASES];
  logic signed [63:0]          next_hpAcc  [PHASES];
  logic signed [63:0]          next_mavAcc [PHASES];
  logic signed [63:0]          next_msqAcc [PHASES];
  logic signed [63:0]          next_pwrAcc [PHASES];
  logic [MAV_W-1:0]            mav      [PHASES];
  logic [23:0]                 vrms     [PHASES];
  logic [23:0]                 watt     [PHASES];
  logic [MAV_W-1:0]            next_mav  [PHASES];
  logic [23:0]                 next_vrms [PHASES];
  logic [23:0]                 next_watt [PHASES];

  // Register port state
  logic [23:0]                 vos      [PHASES];
  logic [23:0]                 next_vos [PHASES];
  logic [31:0]                 next_regRdata;
  logic                        next_regRvalid;

  // Datapath terms for the phase in hand
  logic                        tick;
  logic signed [63:0]          curX, volX, hpDc, hpOut, absOut;
  logic signed [63:0]          mavAvg, msqAvg, pwrAvg, osSum, mavScaled;
  logic [47:0]                 radicand;
  logic [ROOT_W-1:0]           trial;
  logic [47:0]                 trialSq;

  assign tick = (tickCnt == DIV_LAST);

  // Shared arithmetic; mux by phase keeps one multiplier set
  always_comb begin
    curX   = 64'(held[phase].current);
    volX   = 64'(held[phase].voltage);
    hpDc   = hpAcc[phase] >>> HP_SHIFT;
    hpOut  = curX - hpDc;
    absOut = (hpOut < 0) ? -hpOut : hpOut;
    mavAvg = mavAcc[phase] >>> MAV_SHIFT;
    msqAvg = msqAcc[phase] >>> VRMS_SHIFT;
    pwrAvg = pwrAcc[phase] >>> PWR_SHIFT;
    // Offset weighted by 128 and added ahead of the root
    osSum  = msqAvg + (64'(signed'(vos[phase])) <<< VOS_GAIN_SHIFT);
    // A negative sum would give a meaningless root
    if (osSum < 0) begin
      radicand = 48'h000000000000;
    end else if (osSum > 64'sh0000ffffffffffff) begin
      radicand = 48'hffffffffffff;
    end else begin
      radicand = osSum[47:0];
    end
    mavScaled = (mavAvg * 64'(MAV_SCALE)) >>> MAV_SCALE_SHIFT;
    trial     = root | (ROOT_W'(1) << bitIdx);
    trialSq   = 48'(trial) * 48'(trial);
  end

  // Frame sequencer, filters and result words
  always_comb begin
    next_step         = step;
    next_tickCnt      = tick ? 32'h00000000 : tickCnt + 32'h00000001;
    next_phase        = phase;
    next_bitIdx       = bitIdx;
    next_root         = root;
    next_held         = held;
    next_resultUpdate = 1'b0;
    next_hpAcc        = hpAcc;
    next_mavAcc       = mavAcc;
    next_msqAcc       = msqAcc;
    next_pwrAcc       = pwrAcc;
    next_mav          = mav;
    next_vrms         = vrms;
    next_watt         = watt;
    case (step)
      IDLE: begin
        // Samples taken once per 8 kHz tick
        if (tick) begin
          next_held  = phaseSamples;
          next_phase = 2'd0;
          next_step  = FILTER;
        end
      end
      FILTER: begin
        // One update of every filter for this phase
        next_hpAcc[phase]  = hpAcc[phase] + curX - hpDc;
        next_mavAcc[phase] = mavAcc[phase] + absOut - mavAvg;
        next_msqAcc[phase] = msqAcc[phase] + volX * volX - msqAvg;
        // Raw product keeps every harmonic; ripple left for integration
        next_pwrAcc[phase] = pwrAcc[phase] + volX * curX
                             - pwrAvg;
        next_root          = '0;
        next_bitIdx        = 5'(ROOT_W - 1);
        next_step          = ROOT;
      end
      ROOT: begin
        // Bit-serial root, one result bit a cycle
        if (trialSq <= radicand) begin
          next_root = trial;
        end
        if (bitIdx == 5'd0) begin
          next_step = STORE;
        end else begin
          next_bitIdx = bitIdx - 5'd1;
        end
      end
      STORE: begin
        next_mav[phase]  = (mavScaled > 64'sh00000000000fffff) ?
                           20'hfffff : mavScaled[MAV_W-1:0];
        next_vrms[phase] = root;
        // Average power as a fraction of full-scale power over 16
        next_watt[phase] = 24'((pwrAvg >>> WATT_SHIFT));
        if (phase == 2'(PHASES - 1)) begin
          next_resultUpdate = 1'b1;
          next_step         = IDLE;
        end else begin
          next_phase = phase + 2'd1;
          next_step  = FILTER;
        end
      end
      default: next_step = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      step         <= IDLE;
      tickCnt      <= 32'h00000000;
      phase        <= 2'd0;
      bitIdx       <= 5'd0;
      root         <= '0;
      held         <= '0;
      resultUpdate <= 1'b0;
      for (int p = 0; p < PHASES; p++) begin
        hpAcc[p]  <= 64'sh0;
        mavAcc[p] <= 64'sh0;
        msqAcc[p] <= 64'sh0;
        pwrAcc[p] <= 64'sh0;
        mav[p]    <= '0;
        vrms[p]   <= 24'h000000;
        watt[p]   <= 24'h000000;
      end
    end else begin
      step         <= next_step;
      tickCnt      <= next_tickCnt;
      phase        <= next_phase;
      bitIdx       <= next_bitIdx;
      root         <= next_root;
      held         <= next_held;
      resultUpdate <= next_resultUpdate;
      hpAcc        <= next_hpAcc;
      mavAcc       <= next_mavAcc;
      msqAcc       <= next_msqAcc;
      pwrAcc       <= next_pwrAcc;
      mav          <= next_mav;
      vrms         <= next_vrms;
      watt         <= next_watt;
    end
  end

  // Register port: read answers one cycle later, unmapped reads zero
  always_comb begin
    next_vos       = vos;
    next_regRdata  = regRdata;
    next_regRvalid = regReq.read;
    if (regReq.write && regReq.index >= IDX_VOS_BASE &&
        regReq.index < IDX_WATT_BASE) begin
      next_vos[2'(regReq.index - IDX_VOS_BASE)] = regReq.wdata[23:0];
    end
    if (regReq.read) begin
      if (regReq.index < IDX_VRMS_BASE) begin
        next_regRdata = {12'h000, mav[2'(regReq.index)]};
      end else if (regReq.index < IDX_VOS_BASE) begin
        next_regRdata = {8'h00,
                         vrms[2'(regReq.index - IDX_VRMS_BASE)]};
      end else if (regReq.index < IDX_WATT_BASE) begin
        next_regRdata = {4'h0,
          {4{vos[2'(regReq.index - IDX_VOS_BASE)][23]}},
          vos[2'(regReq.index - IDX_VOS_BASE)]};
      end else if (regReq.index <= IDX_LAST) begin
        // Power words readable on the register port, top eight bits zero
        next_regRdata = {8'h00,
                         watt[2'(regReq.index - IDX_WATT_BASE)]};
      end else begin
        next_regRdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int p = 0; p < PHASES; p++) begin
        vos[p] <= VOS_RESET;
      end
      regRdata  <= 32'h00000000;
      regRvalid <= 1'b0;
    end else begin
      vos       <= next_vos;
      regRdata  <= next_regRdata;
      regRvalid <= next_regRvalid;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_frame_latency: assert property (
    (tick && step == IDLE) |-> ##79 resultUpdate)
    else $error("results not refreshed 79 cycles after tick");

  a_mav_padding: assert property (
    (regRvalid && $past(regReq.index) < IDX_VRMS_BASE)
      |-> regRdata[31:20] == 12'h000)
    else $error("mean-abs read has nonzero top bits");

  a_vrms_padding: assert property (
    (regRvalid && $past(regReq.index) >= IDX_VRMS_BASE &&
     $past(regReq.index) < IDX_VOS_BASE) |-> regRdata[31:24] == 8'h00)
    else $error("voltage rms read has nonzero top bits");

  a_offset_readback: assert property (
    (regReq.write && regReq.index == IDX_VOS_BASE)
      ##1 (regReq.read && regReq.index == IDX_VOS_BASE && !regReq.write)
      |=> regRdata == {4'h0, {4{$past(regReq.wdata[23], 2)}},
                       $past(regReq.wdata[23:0], 2)})
    else $error("offset coefficient readback wrong");

  a_clamp_zero: assert property (
    (step == ROOT && osSum < 0) |-> radicand == 48'h000000000000)
    else $error("negative sum not clamped");

  a_root_exact: assert property (
    step == STORE |-> (48'(root) * 48'(root) <= radicand) &&
      (49'(root) + 49'h1) * (49'(root) + 49'h1) > 49'(radicand))
    else $error("root not the floor square root");

  a_watt_scale: assert property (
    resultUpdate |-> watt[2] ==
      24'((pwrAcc[2] >>> PWR_SHIFT) >>> WATT_SHIFT))
    else $error("stored power not scaled from filtered product");

  a_mav_scale: assert property (
    resultUpdate && ((mavAcc[0] >>> MAV_SHIFT) < 64'sh100000) |->
      mav[0] == MAV_W'((((mavAcc[0] >>> MAV_SHIFT) * 64'(MAV_SCALE))
                        >>> MAV_SCALE_SHIFT)))
    else $error("mean-abs result not scaled from average");

  a_results_hold: assert property (
    (step == IDLE && !tick) |=> $stable(watt[0]) && $stable(vrms[0]))
    else $error("result changed outside a sweep");

  c_tick: cover property (tick);
  c_clamp: cover property (step == ROOT && osSum < 0);
  c_neg_power: cover property (resultUpdate && watt[1][23]);
  c_offset_write: cover property (regReq.write &&
                                  regReq.index == IDX_VOS_BASE);

endmodule // phase_rms_and_active_power

// ### verilog/phase_meter_pkg.sv
// Purpose: Shared constants and carriers for the per-phase metering datapath
// Assumes: 125 MHz system clock, 24-bit signed samples, three phases
// Notes:   Register indices are word indices on the serial register port
package phase_meter_pkg;

  // Sample format and phase count
  localparam int SAMPLE_W = 24;
  localparam int PHASES   = 3;

  // Clock and result update rate
  localparam longint CLK_HZ         = 125_000_000;
  localparam longint SAMPLE_RATE_HZ = 8_000;
  localparam int     SAMPLE_DIV_CYC = int'(CLK_HZ / SAMPLE_RATE_HZ);

  // Settling targets; filter shifts below are sized to meet them
  localparam int MAV_SETTLE_MS  = 500;
  localparam int VRMS_SETTLE_MS = 440;

  // Filter shifts (time constant = 2^shift samples at 8 kHz)
  localparam int HP_SHIFT   = 11;
  localparam int MAV_SHIFT  = 9;
  localparam int VRMS_SHIFT = 9;
  localparam int PWR_SHIFT  = 9;

  // Mean-abs scaling: full-scale sine mean-abs lands near 209,686
  localparam logic [15:0] MAV_SCALE       = 16'h0e39;
  localparam int          MAV_SCALE_SHIFT = 16;
  localparam int          MAV_W           = 20;

  // Offset coefficient is weighted by 128 ahead of the root
  localparam int VOS_GAIN_SHIFT = 7;
  localparam int ROOT_W         = 24;

  // Full-scale in-phase power and the stored power scaling
  localparam longint FULL_SCALE_POWER_CONSTANT = 33_516_139;
  localparam int     WATT_SHIFT                = 23;

  // Register word indices
  localparam logic [3:0] IDX_MAV_BASE  = 4'h0;
  localparam logic [3:0] IDX_VRMS_BASE = 4'h3;
  localparam logic [3:0] IDX_VOS_BASE  = 4'h6;
  localparam logic [3:0] IDX_WATT_BASE = 4'h9;
  localparam logic [3:0] IDX_LAST      = 4'hb;

  // Reset values
  localparam logic [23:0] VOS_RESET = 24'h000000;

  // One phase sample pair
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] current;
    logic signed [SAMPLE_W-1:0] voltage;
  } phase_sample_t;

  // Serial register port request
  typedef struct packed {
    logic [3:0]  index;
    logic        write;
    logic        read;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// ### test/meter_host_model.sv
// Purpose: Host-side correction of mean-abs words read from the device
// Assumes: Gain is unsigned Q1.15, offset in result counts
// Notes:   Coefficients live in host memory, never in the device
`timescale 1ns/1ns
module meter_host_model #(
  parameter logic [15:0] MAV_GAIN = 16'h8000,
  parameter logic [19:0] MAV_OFS  = 20'h00000
) (
  input  wire logic [31:0] rawWord,
  output logic      [31:0] corrWord
);
  logic [35:0] scaled;

  // Gain then offset on every word read
  always_comb begin
    scaled   = rawWord[19:0] * MAV_GAIN;
    corrWord = {12'h000, scaled[34:15] - MAV_OFS};
  end
endmodule // meter_host_model

// ### test/phase_rms_and_active_power_tb.sv
// Purpose: Register-level bench for the per-phase metering datapath
// Assumes: Tick divider shortened to 100 cycles
// Notes:   Results are read just after resultUpdate so words are settled
`timescale 1ns/1ns
module phase_rms_and_active_power_tb
  import phase_meter_pkg::*;
;
  localparam int DIV = 100;
  logic                       sys_clk;
  logic                       rst_n;
  phase_sample_t [PHASES-1:0] phaseSamples;
  reg_req_t                   regReq;
  logic [31:0]                regRdata;
  logic                       regRvalid;
  logic                       resultUpdate;
  logic [31:0]                rd;
  logic [31:0]                hostMav;
  logic [31:0]                rdPrev;
  int                         n_fail;
  int                         checks_done;
  int                         gap;

  phase_rms_and_active_power #(.SAMPLE_DIV(DIV), .FUNDAMENTAL_EN(1'b0)) dut_u (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .phaseSamples (phaseSamples),
    .regReq       (regReq),
    .regRdata     (regRdata),
    .regRvalid    (regRvalid),
    .resultUpdate (resultUpdate)
  );

  // Half gain and a small offset so the correction is visible
  meter_host_model #(.MAV_GAIN(16'h4000), .MAV_OFS(20'h00010)) host_u (
    .rawWord  (rd),
    .corrWord (hostMav)
  );

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Range checks: ok flag computed by caller, bound shown on failure
  task automatic chk_ok(input logic ok, input logic [31:0] got,
                        input logic [31:0] bound);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h bound=%h", $time, got, bound);
    end
  endtask

  // Read: answer must be flagged exactly one cycle after the read edge
  task automatic rd_reg(input logic [3:0] idx);
    @(posedge sys_clk);
    regReq.index <= idx;
    regReq.read  <= 1'b1;
    @(posedge sys_clk);
    regReq.read  <= 1'b0;
    #1;
    chk({31'h0, regRvalid}, 32'h1);
    rd = regRdata;
  endtask

  // Write then read the same index on the very next edge
  task automatic wr_rd(input logic [3:0] idx, input logic [31:0] val);
    @(posedge sys_clk);
    regReq.index <= idx;
    regReq.wdata <= val;
    regReq.write <= 1'b1;
    @(posedge sys_clk);
    regReq.write <= 1'b0;
    regReq.read  <= 1'b1;
    @(posedge sys_clk);
    regReq.read  <= 1'b0;
    #1;
    rd = regRdata;
  endtask

  task automatic wr_reg(input logic [3:0] idx, input logic [31:0] val);
    @(posedge sys_clk);
    regReq.index <= idx;
    regReq.wdata <= val;
    regReq.write <= 1'b1;
    @(posedge sys_clk);
    regReq.write <= 1'b0;
  endtask

  // Bounded wait for a sweep end; counts cycles waited in gap
  task automatic wait_upd();
    gap = 0;
    do begin
      @(posedge sys_clk);
      #1;
      gap++;
    end while (resultUpdate !== 1'b1 && gap < 300);
    if (gap >= 300) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      close_out();
    end
  endtask

  initial begin
    n_fail       = 0;
    checks_done  = 0;
    rst_n        = 1'b0;
    regReq       = '0;
    phaseSamples = '0;
    rd           = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // All words zero out of reset, unmapped index 0xc too
    for (int i = 0; i < 13; i++) begin
      rd_reg(i[3:0]);
      chk(rd, 32'h0);
    end
    // Offsets: 24-bit field, sign extended to 28, top four bits zero
    wr_rd(4'h6, 32'h00fffe00);
    chk(rd, 32'h0ffffe00);
    wr_reg(4'h6, 32'hff000200);
    rd_reg(4'h6);
    chk(rd, 32'h00000200);
    wr_reg(4'h7, 32'h00800001);
    rd_reg(4'h7);
    chk(rd, 32'h0f800001);
    wr_reg(4'h8, 32'h00000002);
    // Result words ignore writes
    wr_reg(4'h3, 32'h00123456);
    rd_reg(4'h3);
    chk(rd, 32'h0);
    // Zero input: rms is the root of 128 times the offset alone, zero for B's negative offset
    wait_upd();
    wait_upd();
    chk(gap, DIV);
    rd_reg(4'h3);
    chk(rd, 32'h00000100);
    rd_reg(4'h4);
    chk(rd, 32'h0);
    rd_reg(4'h5);
    chk(rd, 32'h00000010);
    // Steady inputs: A in phase, B inverted current, C no voltage
    wr_reg(4'h6, 32'h0);
    @(posedge sys_clk);
    phaseSamples[0] <= '{current: 24'sh400000, voltage: 24'sh400000};
    phaseSamples[1] <= '{current: -24'sh400000, voltage: 24'sh400000};
    phaseSamples[2] <= '{current: 24'sh400000, voltage: 24'sh0};
    repeat (600 * DIV) @(posedge sys_clk);
    wait_upd();
    rd_reg(4'h9);
    chk_ok(rd[31:24] == 8'h0 && rd[23:0] > 24'h100000
           && rd[23:0] <= 24'h200000, rd, 32'h00200000);
    rd_reg(4'ha);
    chk_ok(rd[31:24] == 8'h0 && rd[23] == 1'b1
           && rd[23:0] < 24'hf00000, rd, 32'h00e00000);
    rd_reg(4'hb);
    chk(rd, 32'h0);
    rd_reg(4'h3);
    chk_ok(rd[31:24] == 8'h0 && rd[23:0] > 24'h200000
           && rd[23:0] <= 24'h400000, rd, 32'h00400000);
    rd_reg(4'h0);
    chk_ok(rd[31:20] == 12'h0 && rd[19:0] != 20'h0,
           rd, 32'h000fffff);
    #1;
    chk(hostMav, {12'h000, {1'b0, rd[19:1]} - 20'h00010});
    // Calibrate at nonzero voltage: A and B see equal voltage
    wr_reg(4'h7, 32'h007fffff);
    wait_upd();
    rd_reg(4'h3);
    rdPrev = rd;
    rd_reg(4'h4);
    chk_ok(rd[23:0] > rdPrev[23:0], rd, rdPrev);
    close_out();
  end
endmodule // phase_rms_and_active_power_tb
